// file: rtl/ilc_checker.sv
// Instruction legality checker with its AXI4-Lite register slave.
// Function
// - Reserved bits written zero read back zero.
// - Unsupported optional instructions raise illegal.
// - 64-bit-only instructions raise illegal.
// - Opcode zero other than the all-zero word, and legacy instructions, raise illegal.
// - Count-register branch without bit two illegal.
// - Branch prediction hint bit is ignored.
// - Record bit on condition moves: no exception.
// - Sign-extend half loads one extra cycle.
// - Update forms block integer co-issue, no latency.
// - Big-endian scalar accesses never alignment-fault.
// - Legacy-endian doubleword crossing raises alignment.
// - Faulting elementary load keeps target unchanged.
// - Direct-store references raise storage or alignment.
// - Load update with base equal target illegal.
// - Update with base zero writes register zero.
// - Zero-length indexed string load: no exception.
// - Invalid load/store record bit leaves field.
// - Conditional word store always updates field.
// - Reservation covers aligned 32-byte granule.
// - Overflow low multiply six cycles, others fewer.
// - Undefined special register: privileged or illegal.
// - External access register access is illegal.
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
module ilc_checker #(
   parameter int unsigned P_GRANULE = ilc_pkg::ILC_GRANULE_BYTES
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire ilc_pkg::ilc_axi_req_t i_axi,
   output ilc_pkg::ilc_axi_rsp_t o_axi,
   input wire ilc_pkg::ilc_dec_t i_dec,
   output ilc_pkg::ilc_exc_t o_exc,
   output ilc_pkg::ilc_info_t o_info
);
   import ilc_pkg::*;

   if (P_GRANULE < 8 || (P_GRANULE & (P_GRANULE - 1)) != 0) begin : g_chk
      $error("Granule must be a power of two of at least eight bytes.");
   end

   ilc_state_t q;
   ilc_state_t d;
   logic [5:0] op;
   logic [9:0] xo;
   logic [8:0] xo9;
   logic [4:0] xa;
   logic [4:0] rt;
   logic [4:0] ra;
   logic [9:0] special_reg_number;
   logic spr_acc;
   logic spr_known;
   logic lwarx;
   logic stwcx;
   logic legacy;

   function automatic logic spr_def(input logic [9:0] s);
      logic hit;
      hit = (s >= ILC_SPR_BAT_LO && s <= ILC_SPR_BAT_HI) || s >= ILC_SPR_IMP_LO;
      for (int i = 0; i < $size(ILC_SPR_DEF); i++) begin
         if (s == ILC_SPR_DEF[i]) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction

   assign op = i_dec.instr[31:26];
   assign xo = i_dec.instr[10:1];
   assign xo9 = i_dec.instr[9:1];
   assign xa = i_dec.instr[5:1];
   assign rt = i_dec.instr[25:21];
   assign ra = i_dec.instr[20:16];
   assign special_reg_number = {i_dec.instr[15:11], i_dec.instr[20:16]};
   assign spr_acc = op == ILC_OP_X && (xo == ILC_XO_MFSPR || xo == ILC_XO_MTSPR);
   assign spr_known = spr_def(special_reg_number);
   assign lwarx = op == ILC_OP_X && xo == ILC_XO_LWARX;
   assign stwcx = op == ILC_OP_X && xo == ILC_XO_STWCX;
   assign legacy = q.ctrl[ILC_CTRL_LE_BIT];

   assign o_axi.awready = !q.aw_ok && !q.bvalid;
   assign o_axi.wready = !q.w_ok && !q.bvalid;
   assign o_axi.bvalid = q.bvalid;
   assign o_axi.bresp = q.bresp;
   assign o_axi.arready = !q.rvalid;
   assign o_axi.rvalid = q.rvalid;
   assign o_axi.rdata = q.rdata;
   assign o_axi.rresp = q.rresp;
   assign o_exc = q.exc;
   assign o_info = q.info;

   always_comb begin
      logic [5:0] dop;
      logic mem_x;
      logic mem;
      logic elem;
      logic multi;
      logic ld;
      logic upd;
      logic fixed;
      logic brx;
      logic ill;
      logic priv;
      logic alg;
      logic [3:0] sz;
      logic [3:0] span;
      logic mis;
      ilc_cause_t cause;
      logic [31:0] rd;
      logic hit;
      dop = op;
      mem_x = 1'b0;
      mem = 1'b0;
      elem = 1'b0;
      multi = 1'b0;
      ld = 1'b0;
      upd = 1'b0;
      fixed = 1'b0;
      brx = 1'b0;
      ill = 1'b0;
      priv = 1'b0;
      alg = 1'b0;
      sz = 4'h4;
      span = 4'h0;
      mis = 1'b0;
      cause = ILC_EXC_NONE;
      rd = 32'h0000_0000;
      hit = 1'b1;
      d = q;

      // Indexed memory forms map onto the matching displacement opcode.
      if (op == ILC_OP_X && xo[4:0] == ILC_XO_MEMX && {1'b1, xo[9:5]} <= ILC_OP_MEM_HI &&
         {1'b1, xo[9:5]} != ILC_OP_LMW && {1'b1, xo[9:5]} != ILC_OP_STMW) begin
         mem_x = 1'b1;
         dop = {1'b1, xo[9:5]};
      end
      if (dop >= ILC_OP_MEM_LO && dop <= ILC_OP_MEM_HI) begin
         mem = 1'b1;
         multi = dop == ILC_OP_LMW || dop == ILC_OP_STMW;
         elem = !multi;
         upd = dop[0] && !multi;
         fixed = dop < ILC_OP_FP_MEM;
         ld = (dop < ILC_OP_FP_MEM) ? (dop == ILC_OP_LMW || (dop != ILC_OP_STMW && !dop[2]))
            : !dop[2];
         if (dop[4]) begin
            sz = dop[1] ? 4'h8 : 4'h4;
         end else if (dop[3]) begin
            sz = 4'h2;
         end else begin
            sz = dop[1] ? 4'h1 : 4'h4;
         end
      end
      if (op == ILC_OP_X) begin
         // Byte reversal is handled by the rotator and adds no latency.
         if (xo == ILC_XO_LWBRX || xo == ILC_XO_STWBRX || xo == ILC_XO_LHBRX ||
            xo == ILC_XO_STHBRX) begin
            brx = 1'b1;
            sz = xo[8] ? 4'h2 : 4'h4;
            ld = !xo[7];
         end
         if (lwarx || stwcx) begin
            brx = 1'b1;
            sz = 4'h4;
            ld = lwarx;
         end
         // A zero-length indexed string load is accepted without exception.
         for (int i = 0; i < $size(ILC_XO_STR); i++) begin
            if (xo == ILC_XO_STR[i]) begin
               mem = 1'b1;
               multi = 1'b1;
               fixed = 1'b1;
               ld = !xo[7];
            end
         end
         if (brx) begin
            mem = 1'b1;
            elem = 1'b1;
            fixed = 1'b1;
         end
      end

      // Optional instructions that are not implemented.
      if (op == ILC_OP_FPS && (xa == ILC_XA_OPT_S[0] || xa == ILC_XA_OPT_S[1])) begin
         ill = 1'b1;
      end
      if (op == ILC_OP_FPD && (xa == ILC_XA_OPT_D[0] || xa == ILC_XA_OPT_D[1])) begin
         ill = 1'b1;
      end
      for (int i = 0; i < $size(ILC_XO_OPT); i++) begin
         if (op == ILC_OP_X && xo == ILC_XO_OPT[i]) begin
            ill = 1'b1;
         end
      end
      // Instructions of 64-bit implementations only.
      for (int i = 0; i < $size(ILC_OP_64); i++) begin
         if (op == ILC_OP_64[i]) begin
            ill = 1'b1;
         end
      end
      for (int i = 0; i < $size(ILC_XO_64); i++) begin
         if (op == ILC_OP_X && xo == ILC_XO_64[i]) begin
            ill = 1'b1;
         end
      end
      for (int i = 0; i < $size(ILC_XO9_64); i++) begin
         if (op == ILC_OP_X && xo9 == ILC_XO9_64[i]) begin
            ill = 1'b1;
         end
      end
      // Opcode zero other than the all-zero word, and legacy instructions.
      if (op == 6'h00 && i_dec.instr != 32'h0000_0000) begin
         ill = 1'b1;
      end
      for (int i = 0; i < $size(ILC_OP_OLD); i++) begin
         if (op == ILC_OP_OLD[i]) begin
            ill = 1'b1;
         end
      end
      for (int i = 0; i < $size(ILC_XO9_OLD); i++) begin
         if (op == ILC_OP_X && xo9 == ILC_XO9_OLD[i]) begin
            ill = 1'b1;
         end
      end
      if (op == ILC_OP_CR && xo == ILC_XO_BCCTR && !i_dec.instr[23]) begin
         ill = 1'b1;
      end
      if (mem && ld && upd && ra == rt) begin
         ill = 1'b1;
      end
      if (spr_acc) begin
         if (special_reg_number == ILC_SPR_EXT) begin
            ill = 1'b1;
         end else if (!spr_known) begin
            priv = i_dec.instr[20];
            ill = ill || !i_dec.instr[20];
         end
      end

      // Alignment is only checked in legacy-endian mode.
      span = {1'b0, i_dec.ea[2:0]} + sz;
      mis = (i_dec.ea[2:0] & (sz[2:0] - 3'h1)) != 3'h0;
      alg = legacy && ((elem && span > 4'h8) || ((lwarx || stwcx) && mis));

      if (ill) begin
         cause = ILC_EXC_ILLEGAL;
      end else if (priv) begin
         cause = ILC_EXC_PRIV;
      end else if (alg) begin
         cause = ILC_EXC_ALIGN;
      end else if (mem && i_dec.direct_store) begin
         cause = ILC_EXC_DSTORE;
      end

      // One cause per instruction, registered with its address.
      d.exc.valid = i_dec.valid && cause != ILC_EXC_NONE;
      d.exc.cause = i_dec.valid ? cause : ILC_EXC_NONE;
      d.exc.pc = i_dec.pc;
      d.info.valid = i_dec.valid;
      d.info.load_extra = (dop == ILC_OP_LHA || dop == ILC_OP_LHAU) ? ILC_LHA_EXTRA : 2'h0;
      d.info.block_int_issue = mem && upd;
      d.info.mul_cycles = 3'h0;
      if (op == ILC_OP_MULLI) begin
         d.info.mul_cycles = ILC_MULI_CYC;
      end else if (op == ILC_OP_X && xo9 == ILC_XO9_MULLW) begin
         d.info.mul_cycles = i_dec.instr[10] ? ILC_MUL_OE_CYC : ILC_MULLW_CYC;
      end else if (op == ILC_OP_X && (xo9 == ILC_XO9_MULH[0] || xo9 == ILC_XO9_MULH[1])) begin
         d.info.mul_cycles = ILC_MULH_CYC;
      end
      // Record bit is honoured only by X forms other than memory accesses and SPR moves; the store always sets it.
      d.info.cr0_wr = cause == ILC_EXC_NONE && (stwcx ||
         (i_dec.instr[0] && op == ILC_OP_X && !mem && !spr_acc) ||
         op == ILC_OP_ADDIC_R || op == ILC_OP_ANDI_R || op == ILC_OP_ANDIS_R);
      d.info.rt_wr = cause == ILC_EXC_NONE && mem && ld && fixed &&
         !(i_dec.page_fault && !multi);
      d.info.ra_wr = cause == ILC_EXC_NONE && mem && upd && !i_dec.page_fault;
      d.info.ea_base_zero = mem && ra == 5'h00;
      d.info.bo_eff = {i_dec.instr[25:22], 1'b0};

      if (i_dec.valid && cause == ILC_EXC_NONE && lwarx) begin
         d.rsv_addr = i_dec.ea & ~(32'(P_GRANULE) - 32'h1);
         d.rsv_valid = 1'b1;
      end else if (i_dec.valid && cause == ILC_EXC_NONE && stwcx) begin
         d.rsv_valid = 1'b0;
      end

      // Register writes take effect once both address and data are held.
      if (i_axi.awvalid && !q.aw_ok && !q.bvalid) begin
         d.aw_ok = 1'b1;
         d.awaddr = i_axi.awaddr;
      end
      if (i_axi.wvalid && !q.w_ok && !q.bvalid) begin
         d.w_ok = 1'b1;
         d.wdata = i_axi.wdata;
         d.wstrb = i_axi.wstrb;
      end
      if (q.bvalid && i_axi.bready) begin
         d.bvalid = 1'b0;
      end
      if (q.aw_ok && q.w_ok) begin
         d.aw_ok = 1'b0;
         d.w_ok = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = ILC_RESP_OKAY;
         case (q.awaddr[4:2])
            ILC_OFF_CTRL[4:2]: begin
               for (int b = 0; b < 4; b++) begin
                  if (q.wstrb[b]) begin
                     d.ctrl[8*b +: 8] = q.wdata[8*b +: 8];
                  end
               end
            end
            ILC_OFF_EXC_CNT[4:2]: begin
               d.exc_cnt = 32'h0000_0000;
            end
            ILC_OFF_STATUS[4:2], ILC_OFF_RSV[4:2]: begin
               d.bresp = ILC_RESP_OKAY;
            end
            default: begin
               d.bresp = ILC_RESP_SLVERR;
            end
         endcase
      end
      // A new exception counts after a same-cycle clear, so none is lost.
      if (d.exc.valid) begin
         d.exc_cnt = d.exc_cnt + 32'h0000_0001;
         d.last_cause = cause;
      end

      case (i_axi.araddr[4:2])
         ILC_OFF_CTRL[4:2]: rd = q.ctrl;
         ILC_OFF_STATUS[4:2]: rd = {28'h000_0000, q.rsv_valid, q.last_cause};
         ILC_OFF_RSV[4:2]: rd = q.rsv_addr;
         ILC_OFF_EXC_CNT[4:2]: rd = q.exc_cnt;
         default: hit = 1'b0;
      endcase
      if (q.rvalid && i_axi.rready) begin
         d.rvalid = 1'b0;
      end
      if (i_axi.arvalid && !q.rvalid) begin
         d.rvalid = 1'b1;
         d.rdata = rd;
         d.rresp = hit ? ILC_RESP_OKAY : ILC_RESP_SLVERR;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= '0;
         q.ctrl <= ILC_CTRL_RST;
      end else begin
         q <= d;
      end
   end

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   property p_opt_illegal;
      i_dec.valid && op == ILC_OP_FPD && xa == ILC_XA_OPT_D[0]
         |=> o_exc.valid && o_exc.cause == ILC_EXC_ILLEGAL;
   endproperty
   a_opt_illegal: assert property (p_opt_illegal) else $error("Optional op not illegal.");

   property p_op64_illegal;
      i_dec.valid && op == ILC_OP_64[2] |=> o_exc.cause == ILC_EXC_ILLEGAL;
   endproperty
   a_op64_illegal: assert property (p_op64_illegal) else $error("64-bit op not illegal.");

   property p_bcctr;
      i_dec.valid && op == ILC_OP_CR && xo == ILC_XO_BCCTR
         |=> (o_exc.cause == ILC_EXC_ILLEGAL) == !$past(i_dec.instr[23]);
   endproperty
   a_bcctr: assert property (p_bcctr) else $error("Count branch form misjudged.");

   property p_lha_lat;
      i_dec.valid && i_dec.instr[31:26] == ILC_OP_LHAU ##1 o_info.valid
         |-> o_info.load_extra == ILC_LHA_EXTRA && o_info.block_int_issue;
   endproperty
   a_lha_lat: assert property (p_lha_lat) else $error("Half load latency wrong.");

   property p_be_noalign;
      i_dec.valid && !legacy && !i_dec.direct_store |=> o_exc.cause != ILC_EXC_ALIGN;
   endproperty
   a_be_noalign: assert property (p_be_noalign) else $error("Alignment fault in big-endian.");

   property p_le_rsv;
      i_dec.valid && legacy && lwarx && i_dec.ea[1:0] != 2'h0 |=> o_exc.cause == ILC_EXC_ALIGN;
   endproperty
   a_le_rsv: assert property (p_le_rsv) else $error("Misaligned reserve load passed.");

   property p_ldu_same;
      i_dec.valid && op == ILC_OP_LHAU && ra == rt |=> o_exc.cause == ILC_EXC_ILLEGAL;
   endproperty
   a_ldu_same: assert property (p_ldu_same) else $error("Update load base equal target.");

   property p_stwcx_cr;
      i_dec.valid && stwcx && !i_dec.instr[0] && !legacy && !i_dec.direct_store
         |=> o_info.cr0_wr;
   endproperty
   a_stwcx_cr: assert property (p_stwcx_cr) else $error("Conditional store left field.");

   property p_granule;
      i_dec.valid && lwarx && !legacy && !i_dec.direct_store
         |=> q.rsv_valid && q.rsv_addr == ($past(i_dec.ea) & ~(32'(P_GRANULE) - 32'h1));
   endproperty
   a_granule: assert property (p_granule) else $error("Reservation granule wrong.");

   property p_mul_oe;
      i_dec.valid && op == ILC_OP_X && xo9 == ILC_XO9_MULLW && i_dec.instr[10]
         |=> o_info.mul_cycles == ILC_MUL_OE_CYC;
   endproperty
   a_mul_oe: assert property (p_mul_oe) else $error("Overflow multiply not six cycles.");

   property p_spr_undef;
      i_dec.valid && spr_acc && !spr_known && special_reg_number != ILC_SPR_EXT
         |=> o_exc.cause == ($past(i_dec.instr[20]) ? ILC_EXC_PRIV : ILC_EXC_ILLEGAL);
   endproperty
   a_spr_undef: assert property (p_spr_undef) else $error("Undefined register cause wrong.");

   property p_ext_reg;
      i_dec.valid && spr_acc && special_reg_number == ILC_SPR_EXT |=> o_exc.cause == ILC_EXC_ILLEGAL;
   endproperty
   a_ext_reg: assert property (p_ext_reg) else $error("External register not illegal.");

   property p_one_cause;
      o_exc.valid |-> o_exc.cause != ILC_EXC_NONE && o_exc.pc == $past(i_dec.pc)
         && $past(i_dec.valid);
   endproperty
   a_one_cause: assert property (p_one_cause) else $error("Cause without its address.");
endmodule

// file: rtl/ilc_pkg.sv
// Constants and types of the instruction legality checker.
package ilc_pkg;
   localparam logic [4:0] ILC_OFF_CTRL = 5'h00;
   localparam logic [4:0] ILC_OFF_STATUS = 5'h04;
   localparam logic [4:0] ILC_OFF_RSV = 5'h08;
   localparam logic [4:0] ILC_OFF_EXC_CNT = 5'h0c;
   localparam logic [31:0] ILC_CTRL_RST = 32'h0000_0000;
   localparam int ILC_CTRL_LE_BIT = 0;
   localparam int ILC_ST_RSV_BIT = 3;
   localparam logic [1:0] ILC_RESP_OKAY = 2'h0;
   localparam logic [1:0] ILC_RESP_SLVERR = 2'h2;
   localparam int unsigned ILC_GRANULE_BYTES = 32;
   localparam logic [1:0] ILC_LHA_EXTRA = 2'h1;
   localparam logic [2:0] ILC_MUL_OE_CYC = 3'h6;
   localparam logic [2:0] ILC_MULH_CYC = 3'h5;
   localparam logic [2:0] ILC_MULLW_CYC = 3'h4;
   localparam logic [2:0] ILC_MULI_CYC = 3'h3;
   localparam logic [5:0] ILC_OP_MULLI = 6'h07;
   localparam logic [5:0] ILC_OP_ADDIC_R = 6'h0d;
   localparam logic [5:0] ILC_OP_CR = 6'h13;
   localparam logic [5:0] ILC_OP_ANDI_R = 6'h1c;
   localparam logic [5:0] ILC_OP_ANDIS_R = 6'h1d;
   localparam logic [5:0] ILC_OP_X = 6'h1f;
   localparam logic [5:0] ILC_OP_MEM_LO = 6'h20;
   localparam logic [5:0] ILC_OP_LHA = 6'h2a;
   localparam logic [5:0] ILC_OP_LHAU = 6'h2b;
   localparam logic [5:0] ILC_OP_LMW = 6'h2e;
   localparam logic [5:0] ILC_OP_STMW = 6'h2f;
   localparam logic [5:0] ILC_OP_FP_MEM = 6'h30;
   localparam logic [5:0] ILC_OP_MEM_HI = 6'h37;
   localparam logic [5:0] ILC_OP_FPS = 6'h3b;
   localparam logic [5:0] ILC_OP_FPD = 6'h3f;
   localparam logic [4:0] ILC_XO_MEMX = 5'h17;
   localparam logic [9:0] ILC_XO_LWARX = 10'd20;
   localparam logic [9:0] ILC_XO_STWCX = 10'd150;
   localparam logic [9:0] ILC_XO_LWBRX = 10'd534;
   localparam logic [9:0] ILC_XO_STWBRX = 10'd662;
   localparam logic [9:0] ILC_XO_LHBRX = 10'd790;
   localparam logic [9:0] ILC_XO_STHBRX = 10'd918;
   localparam logic [9:0] ILC_XO_STR [4] = '{10'd533, 10'd597, 10'd661, 10'd725};
   localparam logic [9:0] ILC_XO_MFSPR = 10'd339;
   localparam logic [9:0] ILC_XO_MTSPR = 10'd467;
   localparam logic [9:0] ILC_XO_BCCTR = 10'd528;
   localparam logic [9:0] ILC_XO_OPT [3] = '{10'd370, 10'd310, 10'd438};
   localparam logic [4:0] ILC_XA_OPT_S [2] = '{5'd24, 5'd22};
   localparam logic [4:0] ILC_XA_OPT_D [2] = '{5'd26, 5'd22};
   localparam logic [8:0] ILC_XO9_MULLW = 9'd235;
   localparam logic [8:0] ILC_XO9_MULH [2] = '{9'd75, 9'd11};
   localparam logic [5:0] ILC_OP_64 [4] = '{6'd2, 6'd30, 6'd58, 6'd62};
   localparam logic [9:0] ILC_XO_64 [14] = '{10'd21, 10'd53, 10'd149, 10'd181, 10'd341,
      10'd373, 10'd84, 10'd214, 10'd27, 10'd539, 10'd794, 10'd58, 10'd986, 10'd68};
   localparam logic [8:0] ILC_XO9_64 [6] = '{9'd9, 9'd73, 9'd233, 9'd457, 9'd489, 9'd413};
   localparam logic [5:0] ILC_OP_OLD [2] = '{6'd9, 6'd22};
   localparam logic [8:0] ILC_XO9_OLD [6] = '{9'd264, 9'd360, 9'd488, 9'd107, 9'd331, 9'd363};
   localparam logic [9:0] ILC_SPR_EXT = 10'd282;
   localparam logic [9:0] ILC_SPR_DEF [18] = '{10'd1, 10'd8, 10'd9, 10'd18, 10'd19, 10'd22,
      10'd25, 10'd26, 10'd27, 10'd268, 10'd269, 10'd272, 10'd273, 10'd274, 10'd275, 10'd284,
      10'd285, 10'd287};
   localparam logic [9:0] ILC_SPR_BAT_LO = 10'd528;
   localparam logic [9:0] ILC_SPR_BAT_HI = 10'd543;
   localparam logic [9:0] ILC_SPR_IMP_LO = 10'd1008;
   typedef enum logic [2:0] {ILC_EXC_NONE, ILC_EXC_ILLEGAL, ILC_EXC_PRIV, ILC_EXC_ALIGN,
      ILC_EXC_DSTORE} ilc_cause_t;
   typedef struct packed {logic valid; logic [31:0] instr; logic [31:0] pc; logic [31:0] ea;
      logic direct_store; logic page_fault;} ilc_dec_t;
   typedef struct packed {logic valid; ilc_cause_t cause; logic [31:0] pc;} ilc_exc_t;
   typedef struct packed {logic valid; logic [1:0] load_extra; logic block_int_issue;
      logic [2:0] mul_cycles; logic cr0_wr; logic rt_wr; logic ra_wr; logic ea_base_zero;
      logic [4:0] bo_eff;} ilc_info_t;
   typedef struct packed {logic awvalid; logic [4:0] awaddr; logic wvalid; logic [31:0] wdata;
      logic [3:0] wstrb; logic bready; logic arvalid; logic [4:0] araddr; logic rready;} ilc_axi_req_t;
   typedef struct packed {logic awready; logic wready; logic bvalid; logic [1:0] bresp;
      logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;} ilc_axi_rsp_t;
   typedef struct packed {logic aw_ok; logic [4:0] awaddr; logic w_ok; logic [31:0] wdata;
      logic [3:0] wstrb; logic bvalid; logic [1:0] bresp; logic rvalid; logic [31:0] rdata;
      logic [1:0] rresp; logic [31:0] ctrl; logic [31:0] rsv_addr; logic rsv_valid;
      logic [31:0] exc_cnt; ilc_cause_t last_cause; ilc_exc_t exc; ilc_info_t info;} ilc_state_t;
endpackage

// file: testbench/ilc_checker_tb.sv
// Self-checking bench for the instruction legality checker.
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
   $display("[FAIL] %0t got %h expected %h", $time, g, e); end end
module ilc_checker_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import ilc_pkg::*;
   localparam ilc_cause_t NO = ILC_EXC_NONE;
   localparam ilc_cause_t IL = ILC_EXC_ILLEGAL;
   localparam ilc_cause_t AL = ILC_EXC_ALIGN;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic go = 1'b0;
   logic [31:0] word = 32'h0, eaddr = 32'h0, rd, seed = 32'h345e, pc_exp = 32'h0;
   logic [1:0] flags = 2'h0, resp;
   logic [31:0] opt [7] = '{32'h7c00_02e4, 32'h7c00_026c, 32'h7c00_036c, 32'hec00_0030,
      32'hec00_002c, 32'hfc00_0034, 32'hfc00_002c};
   ilc_axi_req_t req = '0;
   ilc_axi_rsp_t rsp;
   ilc_dec_t dec;
   ilc_exc_t exc;
   ilc_info_t info;
   int err_count = 0, checks_done = 0;
   ilc_fetch_model u_ilc_fetch_model (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_go(go),
      .i_word(word), .i_ea(eaddr), .i_flags(flags), .o_dec(dec));
   ilc_checker #(.P_GRANULE(32)) u_ilc_checker (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_axi(req),
      .o_axi(rsp), .i_dec(dec), .o_exc(exc), .o_info(info));
   initial begin
      forever #2.5 i_clk = ~i_clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [31:0] xf(input logic [9:0] xo, input logic rc);
      return {6'h1f, 15'h0, xo, rc};
   endfunction
   function automatic logic [31:0] sp(input logic [9:0] f);
      return {6'h1f, 5'h0, f, 10'd339, 1'b0};
   endfunction
   function automatic ilc_cause_t exp_al(input logic le, input logic [31:0] ea, input int sz);
      return (le && (int'(ea[2:0]) + sz > 8)) ? AL : NO;
   endfunction
   task automatic axi(input logic wr, input logic [4:0] a, input logic [31:0] d);
      logic aw, w, ar, done;
      @(posedge i_clk);
      req <= '{awvalid: wr, awaddr: a, wvalid: wr, wdata: d, wstrb: 4'hf, bready: wr,
         arvalid: !wr, araddr: a, rready: !wr};
      for (int n = 0; n < 40; n++) begin
         @(negedge i_clk);
         aw = rsp.awready && req.awvalid;
         w = rsp.wready && req.wvalid;
         ar = rsp.arready && req.arvalid;
         done = wr ? rsp.bvalid : rsp.rvalid;
         resp = wr ? rsp.bresp : rsp.rresp;
         rd = rsp.rdata;
         @(posedge i_clk);
         if (aw) req.awvalid <= 1'b0;
         if (w) req.wvalid <= 1'b0;
         if (ar) req.arvalid <= 1'b0;
         if (done) begin
            req.bready <= 1'b0;
            req.rready <= 1'b0;
            return;
         end
      end
      err_count++;
      $display("[FAIL] %0t bus answer missing", $time);
      wrap_up();
   endtask
   task automatic run(input logic [31:0] w, input ilc_cause_t c,
      input logic [31:0] ea = 32'h0, input logic [1:0] f = 2'h0);
      @(posedge i_clk);
      go <= 1'b1;
      word <= w;
      eaddr <= ea;
      flags <= f;
      @(posedge i_clk);
      go <= 1'b0;
      #1;
      `CHK(exc.cause, c)
      if (c != NO) `CHK({exc.valid, exc.pc}, {1'b1, pc_exp})
      pc_exp += 32'h4;
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      #100000;
      err_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      wrap_up();
   end
   initial begin
      repeat (10) @(posedge i_clk);
      i_rst_n <= 1'b1;
      axi(1'b0, ILC_OFF_CTRL, 32'h0);
      `CHK(rd, ILC_CTRL_RST)
      axi(1'b1, ILC_OFF_CTRL, 32'hffff_fffe);
      `CHK(resp, ILC_RESP_OKAY)
      axi(1'b1, ILC_OFF_CTRL, 32'h0);
      axi(1'b0, ILC_OFF_CTRL, 32'h0);
      `CHK(rd, 32'h0)
      axi(1'b0, 5'h10, 32'h0);
      `CHK({resp, rd}, {ILC_RESP_SLVERR, 32'h0})
      $display("register test done");
      run(32'h0000_0001, IL);
      run(32'h2400_0000, IL);
      run(32'h0800_0000, IL);
      foreach (opt[i]) run(opt[i], IL);
      run(32'h4c00_0420, IL);
      run(32'h4e80_0420, NO);
      run(32'h41a0_0000, NO);
      `CHK(info.bo_eff, 5'b01100)
      run(32'h4c00_0203, NO);
      run(32'ha800_0000, NO);
      `CHK(info.load_extra, 2'h1)
      run(32'ha422_0000, NO);
      `CHK({info.load_extra, info.block_int_issue}, 3'b001)
      run(32'h8463_0000, IL);
      run(32'h8460_0000, NO, 32'h40);
      `CHK({info.ea_base_zero, info.ra_wr}, 2'b11)
      run(xf(10'd533, 1'b0), NO);
      run(xf(10'd23, 1'b1), NO);
      `CHK(info.cr0_wr, 1'b0)
      run(xf(10'd150, 1'b0), NO);
      `CHK(info.cr0_wr, 1'b1)
      run(sp({5'd16, 5'd0}), ILC_EXC_PRIV);
      run(sp({5'd2, 5'd0}), IL);
      run(sp({5'd26, 5'd8}), IL);
      for (int rc = 0; rc < 2; rc++) begin
         run(xf({1'b1, 9'd235}, rc[0]), NO);
         `CHK(info.mul_cycles, 3'h6)
      end
      run(xf({1'b0, 9'd235}, 1'b0), NO);
      `CHK(info.mul_cycles, 3'h4)
      run(32'h1c00_0000, NO);
      `CHK(info.mul_cycles, 3'h3)
      run(xf({1'b0, 9'd75}, 1'b0), NO);
      `CHK(info.mul_cycles, 3'h5)
      run(xf(10'd20, 1'b0), NO, 32'h1234_5677);
      axi(1'b0, ILC_OFF_RSV, 32'h0);
      `CHK(rd, 32'h1234_5677 & ~32'd31)
      axi(1'b0, ILC_OFF_STATUS, 32'h0);
      `CHK(rd, {28'h000_0000, 1'b1, 3'(IL)})
      run(32'h8000_0000, NO, 32'h0000_0ffe, 2'h1);
      `CHK(info.rt_wr, 1'b0)
      run(32'h8000_0000, ILC_EXC_DSTORE, 32'h100, 2'h2);
      $display("decode test done");
      for (int le = 0; le < 2; le++) begin
         axi(1'b1, ILC_OFF_CTRL, le);
         repeat (20) begin
            seed = lfsr(seed);
            run(seed[31] ? 32'h8000_0000 : 32'ha000_0000, exp_al(le[0], seed, seed[31] ? 4 : 2),
               seed);
         end
      end
      run(xf(10'd20, 1'b0), AL, 32'h2);
      run(32'h8000_0000, AL, 32'h105, 2'h2);
      $display("alignment test done");
      wrap_up();
   end
endmodule

// file: testbench/ilc_fetch_model.sv
// Fetch and decode stage model that presents one instruction per request.
module ilc_fetch_model (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_go,
   input wire logic [31:0] i_word,
   input wire logic [31:0] i_ea,
   input wire logic [1:0] i_flags,
   output ilc_pkg::ilc_dec_t o_dec
);
   timeunit 1ns;
   timeprecision 100ps;
   import ilc_pkg::*;
   logic [31:0] pc_q;
   logic [31:0] last_q;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pc_q <= 32'h0;
         last_q <= 32'h0;
      end else if (i_go) begin
         pc_q <= pc_q + 32'h4;
         last_q <= i_word;
      end
   end
   // Between instructions the word lines show the inverse of the last word.
   assign o_dec = '{valid: i_go, instr: i_go ? i_word : ~last_q, pc: pc_q, ea: i_ea,
      direct_store: i_flags[1], page_fault: i_flags[0]};
endmodule
